// *** rfs_apb.sv ***
/*
 * rfs_apb: APB slave front end; decodes the address, times the answer.
 * Assumes a compliant APB master; the register file lives in the parent.
 */
`timescale 1ns/100ps
module rfs_apb
(
   input  wire logic                            clk_i,
   input  wire logic                            rst_n_i,
   input  wire logic                            psel_i,
   input  wire logic                            penable_i,
   input  wire logic                            pwrite_i,
   input  wire logic [rfs_pkg::APB_AW-1:0]      paddr_i,
   input  wire logic [rfs_pkg::APB_DW-1:0]      rdata_i,
   output logic      [rfs_pkg::NUM_REG-1:0]     sel_o,
   output logic                                 wr_o,
   output logic                                 pready_o,
   output logic                                 pslverr_o,
   output logic      [rfs_pkg::APB_DW-1:0]      prdata_o
);

   logic                        setup;
   logic                        next_pready;
   logic                        next_pslverr;
   logic [rfs_pkg::APB_DW-1:0]  next_prdata;

   always_comb
   begin
      sel_o = '0;
      sel_o[rfs_pkg::SEL_RXSTAT] = (paddr_i == rfs_pkg::OFS_RXSTAT);
      sel_o[rfs_pkg::SEL_DCFG2]  = (paddr_i == rfs_pkg::OFS_DCFG2);
      sel_o[rfs_pkg::SEL_EOBT]   = (paddr_i == rfs_pkg::OFS_EOBT);
      sel_o[rfs_pkg::SEL_DESC]   = (paddr_i == rfs_pkg::OFS_DESC);
   end

   // answer is prepared in setup so pready and data come from flops
   assign setup = psel_i & ~penable_i;
   assign wr_o  = psel_i & penable_i & pready_o & pwrite_i & (|sel_o);

   always_comb
   begin
      next_pready  = setup;
      next_pslverr = setup & ~(|sel_o);
      next_prdata  = prdata_o;
      if (setup)
      begin
         next_prdata = (pwrite_i || !(|sel_o)) ? '0 : rdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end
      else
      begin
         pready_o  <= next_pready;
         pslverr_o <= next_pslverr;
         prdata_o  <= next_prdata;
      end
   end

endmodule

// *** rfs_net_model.sv ***
/*
 * rfs_net_model: network side seen through the coder and transceiver.
 * Assumes the caller enters send just after a rising clock edge.
 */
`timescale 1ns/100ps
module rfs_net_model
(
   input  wire logic        clk_i,
   output logic             st_o,
   output logic             en_o,
   output logic             col_o,
   output logic             car_o,
   output logic [5:0]       q_o,
   output logic [15:0]      rc_o
);
   initial
   begin
      {st_o, en_o, col_o, car_o, q_o, rc_o} = '0;
   end
   // q is {accept, group, bcast, fcs bad, misalign, runt}
   task send(input logic [5:0] q, input logic c, input logic cr,
             input logic [15:0] rc, input int len);
      st_o <= 1'b1;
      car_o <= cr;
      @(posedge clk_i);
      st_o <= 1'b0;
      col_o <= c;
      @(posedge clk_i);
      col_o <= 1'b0;
      repeat (len) @(posedge clk_i);
      en_o <= 1'b1;
      q_o <= q;
      rc_o <= rc;
      @(posedge clk_i);
      // qualifiers expire with the end pulse; never leave them stale
      en_o <= 1'b0;
      q_o <= ~q;
      rc_o <= ~rc;
   endtask
endmodule

// *** rfs_pkg.sv ***
/*
 * rfs_pkg: shared constants for the receive loopback and status block.
 * Assumes a 32-bit APB register bus with one aligned word per register.
 */
package rfs_pkg;

   // register data width and word count width
   localparam int unsigned REG_W   = 16;
   localparam int unsigned CNT_W   = 16;
   localparam int unsigned APB_AW  = 12;
   localparam int unsigned APB_DW  = 32;
   localparam int unsigned NUM_REG = 4;

   // byte addresses
   localparam logic [APB_AW-1:0] OFS_RXSTAT = 12'h000;
   localparam logic [APB_AW-1:0] OFS_DCFG2  = 12'h004;
   localparam logic [APB_AW-1:0] OFS_EOBT   = 12'h008;
   localparam logic [APB_AW-1:0] OFS_DESC   = 12'h00c;

   // one-hot select indexes
   localparam int unsigned SEL_RXSTAT = 0;
   localparam int unsigned SEL_DCFG2  = 1;
   localparam int unsigned SEL_EOBT   = 2;
   localparam int unsigned SEL_DESC   = 3;

   // status flag bit positions
   localparam int unsigned FLAG_W      = 9;
   localparam int unsigned BIT_OK      = 0;
   localparam int unsigned BIT_LOOPED  = 1;
   localparam int unsigned BIT_ALIGN   = 2;
   localparam int unsigned BIT_FCS     = 3;
   localparam int unsigned BIT_COL     = 4;
   localparam int unsigned BIT_CARRIER = 5;
   localparam int unsigned BIT_FINAL   = 6;
   localparam int unsigned BIT_BCAST   = 7;
   localparam int unsigned BIT_GROUP   = 8;

   // loopback select field
   localparam int unsigned LOOP_LSB = 9;
   localparam int unsigned LOOP_W   = 2;
   localparam int unsigned FILT_W   = 5;
   localparam int unsigned XCVR_BIT = 6;

   // flags refreshed at each packet start
   localparam logic [FLAG_W-1:0] CLR_MASK = 9'h1cf;

   // reset values
   localparam logic [LOOP_W-1:0] LOOP_RST = 2'h0;
   localparam logic [REG_W-1:0]  DCFG_RST = 16'h0000;
   localparam logic [CNT_W-1:0]  EOBT_RST = 16'h0000;
   localparam logic [FLAG_W-1:0] FLAG_RST = 9'h000;

   typedef enum logic [LOOP_W-1:0] {
      LOOP_NONE = 2'h0,
      LOOP_MAC  = 2'h1,
      LOOP_CODE = 2'h2,
      LOOP_XCVR = 2'h3
   } rfs_loop_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RECV = 3'h2,
      ST_POST = 3'h4
   } rfs_state_t;

endpackage

// *** rfs_sva.sv ***
/*
 * rfs_sva: timing checks on the receive status and loopback ports.
 * Assumes it is bound to rfs_top and sees only that module's ports.
 */
`timescale 1ns/100ps
module rfs_sva
(
   input wire logic                          clk_i,
   input wire logic                          rst_n_i,
   input wire logic                          psel_i,
   input wire logic                          penable_i,
   input wire logic                          pwrite_i,
   input wire logic [rfs_pkg::APB_AW-1:0]    paddr_i,
   input wire logic [rfs_pkg::APB_DW-1:0]    pwdata_i,
   input wire logic [3:0]                    pstrb_i,
   input wire logic                          pready_o,
   input wire logic                          rx_start_i,
   input wire logic                          rx_end_i,
   input wire logic                          rx_accept_i,
   input wire logic                          rx_group_i,
   input wire logic                          rx_fcs_bad_i,
   input wire logic                          rx_misalign_i,
   input wire logic                          rx_runt_i,
   input wire logic                          rx_col_i,
   input wire logic [rfs_pkg::LOOP_W-1:0]    loop_mode_o,
   input wire logic [rfs_pkg::REG_W-1:0]     desc_status_o,
   input wire logic                          desc_valid_o
);
   logic       in_pkt;
   logic       col_seen;
   logic       next_in_pkt;
   logic       next_col;
   logic       ev_end;
   logic       col_any;
   logic       fcs_only;
   logic       aln_err;
   logic       clean;
   logic       wr0;
   logic [1:0] wsel;
   assign ev_end = in_pkt && rx_end_i;
   assign col_any = col_seen | rx_col_i;
   // expected error terms, taken from the qualifiers at the end pulse
   assign fcs_only = rx_fcs_bad_i & ~rx_misalign_i;
   assign aln_err = rx_fcs_bad_i & rx_misalign_i;
   assign clean = ~rx_fcs_bad_i & ~rx_runt_i & ~col_any;
   assign wr0 = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[1]
      && paddr_i == rfs_pkg::OFS_RXSTAT;
   assign wsel = pwdata_i[10:9];
   // an end outside a packet is ignored, so track reception here
   always_comb
   begin
      next_in_pkt = ev_end ? 1'b0 : (rx_start_i | in_pkt);
      next_col = (rx_start_i && !ev_end) ? 1'b0
               : (col_seen | (in_pkt & rx_col_i));
   end
   always_ff @(posedge clk_i)
   begin
      in_pkt <= rst_n_i & next_in_pkt;
      col_seen <= rst_n_i & next_col;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_acc;
      ev_end && rx_accept_i;
   endsequence
   sequence s_rej;
      ev_end && !rx_accept_i;
   endsequence
   sequence s_wr0;
      wr0;
   endsequence
   property p_grp;
      s_acc |-> ##2 desc_valid_o && desc_status_o[8] == $past(rx_group_i, 2);
   endproperty
   a_grp: assert property (p_grp) else $error("group flag wrong");
   property p_col;
      s_acc |-> ##2 desc_status_o[4] == $past(col_any, 2);
   endproperty
   a_col: assert property (p_col) else $error("collision flag wrong");
   property p_fcs;
      s_acc |-> ##2 desc_status_o[3] == $past(fcs_only, 2);
   endproperty
   a_fcs: assert property (p_fcs) else $error("fcs flag wrong");
   property p_aln;
      s_acc |-> ##2 desc_status_o[2] == $past(aln_err, 2);
   endproperty
   a_aln: assert property (p_aln) else $error("align flag wrong");
   property p_ok;
      s_acc |-> ##2 desc_status_o[0] == $past(clean, 2);
   endproperty
   a_ok: assert property (p_ok) else $error("ok flag wrong");
   property p_lbk;
      s_acc |-> ##2 desc_status_o[1]
         == (desc_status_o[0] && $past(loop_mode_o, 2) != 2'h0);
   endproperty
   a_lbk: assert property (p_lbk) else $error("looped flag wrong");
   property p_rej;
      s_rej |-> ##1 !desc_valid_o ##1 !desc_valid_o;
   endproperty
   a_rej: assert property (p_rej) else $error("descriptor for reject");
   property p_lw;
      s_wr0 |=> loop_mode_o == $past(wsel);
   endproperty
   a_lw: assert property (p_lw) else $error("loop select not written");
   property p_lh;
      !wr0 |=> $stable(loop_mode_o);
   endproperty
   a_lh: assert property (p_lh) else $error("loop select moved");
endmodule

// *** rfs_top.sv ***
/*
 * rfs_top: receive loopback selection and per-packet receive status.
 * Assumes a receive engine that pulses start and end of each packet,
 * holds the packet qualifiers valid with the end pulse, and reports
 * the remaining buffer word count after the packet is buffered.
 */
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// Function
// - two-bit loopback select picks normal, MAC, coder or transceiver path
// - group address flag set for accepted multicast packets
// - all-stations flag set for accepted broadcast packets
// - final packet flag set for accepted packets when remaining words at or below threshold
// - carrier activity flag follows carrier sense
// - collision flag set when collision seen during reception
// - fcs error flag set on bad check sequence unless misaligned too
// - misalign flag set only when misframed and check sequence bad
// - looped packet flag set when looped packet received without error
// - received-ok flag set only without fcs, align, runt or collision error
// - flags 8 to 6 and 3 to 0 clear at start of next packet
// - accepted packet gets full register copy as descriptor status
module rfs_top
#(
   parameter int unsigned CNT_W = rfs_pkg::CNT_W
)
(
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   input  wire logic                         psel_i,
   input  wire logic                         penable_i,
   input  wire logic                         pwrite_i,
   input  wire logic [rfs_pkg::APB_AW-1:0]   paddr_i,
   input  wire logic [rfs_pkg::APB_DW-1:0]   pwdata_i,
   input  wire logic [3:0]                   pstrb_i,
   output logic      [rfs_pkg::APB_DW-1:0]   prdata_o,
   output logic                              pready_o,
   output logic                              pslverr_o,
   input  wire logic                         rx_start_i,
   input  wire logic                         rx_end_i,
   input  wire logic                         rx_accept_i,
   input  wire logic                         rx_group_i,
   input  wire logic                         rx_bcast_i,
   input  wire logic                         rx_fcs_bad_i,
   input  wire logic                         rx_misalign_i,
   input  wire logic                         rx_runt_i,
   input  wire logic                         rx_col_i,
   input  wire logic                         carrier_activity_i,
   input  wire logic [CNT_W-1:0]             remaining_word_count_i,
   output logic      [rfs_pkg::LOOP_W-1:0]   loop_mode_o,
   output logic                              xcvr_loop_o,
   output logic      [rfs_pkg::REG_W-1:0]    desc_status_o,
   output logic                              desc_valid_o
);

   localparam int unsigned RW = rfs_pkg::REG_W;
   localparam int unsigned FW = rfs_pkg::FLAG_W;
   localparam int unsigned LW = rfs_pkg::LOOP_W;

   // bus front end
   logic [rfs_pkg::NUM_REG-1:0]  sel;
   logic                         wr;
   logic [rfs_pkg::APB_DW-1:0]   rdata;

   // register file
   logic [LW-1:0]     loop_sel;
   logic [LW-1:0]     next_loop_sel;
   logic [RW-1:0]     data_config_two;
   logic [RW-1:0]     next_data_config_two;
   logic [CNT_W-1:0]  end_of_buffer_threshold;
   logic [CNT_W-1:0]  next_end_of_buffer_threshold;

   // status flags and packet tracking
   logic [FW-1:0]     flags;
   logic [FW-1:0]     next_flags;
   logic              col_seen;
   logic              next_col_seen;
   logic              acc_q;
   logic              next_acc_q;
   rfs_pkg::rfs_state_t state;
   rfs_pkg::rfs_state_t next_state;

   // registered outputs
   logic              next_xcvr_loop;
   logic [RW-1:0]     next_desc_status;
   logic              next_desc_valid;

   // packet verdict terms
   logic              end_evt;
   logic              col_any;
   logic              bad_fcs;
   logic              bad_align;
   logic              good;
   logic              final_in_area;
   logic [RW-1:0]     status_word;

   rfs_apb u_apb
   (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .rdata_i   (rdata),
      .sel_o     (sel),
      .wr_o      (wr),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .prdata_o  (prdata_o)
   );

   // byte-lane merge of a 16-bit register
   function automatic logic [RW-1:0] merge16
   (
      input logic [RW-1:0]              old_v,
      input logic [rfs_pkg::APB_DW-1:0] wd,
      input logic [3:0]                 strb
   );
      logic [RW-1:0] v;
      v = old_v;
      if (strb[0])
      begin
         v[7:0] = wd[7:0];
      end
      if (strb[1])
      begin
         v[15:8] = wd[15:8];
      end
      return v;
   endfunction

   // filter enable bits are outside this block and read as zero
   assign status_word = {{rfs_pkg::FILT_W{1'b0}}, loop_sel, flags};

   always_comb
   begin
      rdata = '0;
      case (1'b1)
         sel[rfs_pkg::SEL_RXSTAT]:
         begin
            rdata[RW-1:0] = status_word;
         end
         sel[rfs_pkg::SEL_DCFG2]:
         begin
            rdata[RW-1:0] = data_config_two;
         end
         sel[rfs_pkg::SEL_EOBT]:
         begin
            rdata[CNT_W-1:0] = end_of_buffer_threshold;
         end
         sel[rfs_pkg::SEL_DESC]:
         begin
            rdata[RW-1:0] = desc_status_o;
         end
         default:
         begin
            rdata = '0;
         end
      endcase
   end

   // software writes
   always_comb
   begin
      next_loop_sel                = loop_sel;
      next_data_config_two         = data_config_two;
      next_end_of_buffer_threshold = end_of_buffer_threshold;
      if (wr && sel[rfs_pkg::SEL_RXSTAT] && pstrb_i[1])
      begin
         next_loop_sel = pwdata_i[rfs_pkg::LOOP_LSB +: LW];
      end
      if (wr && sel[rfs_pkg::SEL_DCFG2])
      begin
         next_data_config_two = merge16(data_config_two, pwdata_i, pstrb_i);
      end
      if (wr && sel[rfs_pkg::SEL_EOBT])
      begin
         next_end_of_buffer_threshold =
            merge16(end_of_buffer_threshold, pwdata_i, pstrb_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         loop_sel                <= rfs_pkg::LOOP_RST;
         data_config_two         <= rfs_pkg::DCFG_RST;
         end_of_buffer_threshold <= rfs_pkg::EOBT_RST;
      end
      else
      begin
         loop_sel                <= next_loop_sel;
         data_config_two         <= next_data_config_two;
         end_of_buffer_threshold <= next_end_of_buffer_threshold;
      end
   end

   // packet sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         rfs_pkg::ST_IDLE:
         begin
            if (rx_start_i)
            begin
               next_state = rfs_pkg::ST_RECV;
            end
         end
         rfs_pkg::ST_RECV:
         begin
            if (rx_end_i)
            begin
               next_state = rfs_pkg::ST_POST;
            end
         end
         rfs_pkg::ST_POST:
         begin
            next_state = rx_start_i ? rfs_pkg::ST_RECV : rfs_pkg::ST_IDLE;
         end
         default:
         begin
            next_state = rfs_pkg::ST_IDLE;
         end
      endcase
   end

   assign end_evt = (state == rfs_pkg::ST_RECV) && rx_end_i;
   assign col_any = col_seen | rx_col_i;
   // misframing counts only with bad fcs
   assign bad_align = rx_fcs_bad_i & rx_misalign_i;
   assign bad_fcs = rx_fcs_bad_i & ~rx_misalign_i;
   assign good = ~rx_fcs_bad_i & ~rx_runt_i & ~col_any;
   assign final_in_area =
      (remaining_word_count_i <= end_of_buffer_threshold);

   always_comb
   begin
      next_flags    = flags;
      next_col_seen = col_seen;
      next_acc_q    = acc_q;
      next_flags[rfs_pkg::BIT_CARRIER] = carrier_activity_i;
      if (rx_start_i)
      begin
         next_flags    = next_flags & ~rfs_pkg::CLR_MASK;
         next_col_seen = 1'b0;
      end
      if ((state == rfs_pkg::ST_RECV) && rx_col_i)
      begin
         next_col_seen = 1'b1;
      end
      // end-of-packet results are applied after the clear, so they win
      if (end_evt)
      begin
         next_acc_q = rx_accept_i;
         if (rx_accept_i && rx_group_i)
         begin
            next_flags[rfs_pkg::BIT_GROUP] = 1'b1;
         end
         if (rx_accept_i && rx_bcast_i)
         begin
            next_flags[rfs_pkg::BIT_BCAST] = 1'b1;
         end
         if (rx_accept_i && final_in_area)
         begin
            next_flags[rfs_pkg::BIT_FINAL] = 1'b1;
         end
         next_flags[rfs_pkg::BIT_COL] = col_any;
         if (bad_fcs)
         begin
            next_flags[rfs_pkg::BIT_FCS] = 1'b1;
         end
         if (bad_align)
         begin
            next_flags[rfs_pkg::BIT_ALIGN] = 1'b1;
         end
         if (good && (loop_sel != rfs_pkg::LOOP_NONE))
         begin
            next_flags[rfs_pkg::BIT_LOOPED] = 1'b1;
         end
         if (good)
         begin
            next_flags[rfs_pkg::BIT_OK] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state    <= rfs_pkg::ST_IDLE;
         flags    <= rfs_pkg::FLAG_RST;
         col_seen <= 1'b0;
         acc_q    <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         flags    <= next_flags;
         col_seen <= next_col_seen;
         acc_q    <= next_acc_q;
      end
   end

   // outputs toward the datapath and descriptor writer
   always_comb
   begin
      next_desc_status = desc_status_o;
      next_desc_valid  = 1'b0;
      // transceiver path needs config-two bit too
      next_xcvr_loop = (loop_sel == rfs_pkg::LOOP_XCVR) &&
                       data_config_two[rfs_pkg::XCVR_BIT];
      // copy whole register for accepted packet
      if ((state == rfs_pkg::ST_POST) && acc_q)
      begin
         next_desc_status = status_word;
         next_desc_valid  = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         loop_mode_o   <= rfs_pkg::LOOP_RST;
         xcvr_loop_o   <= 1'b0;
         desc_status_o <= '0;
         desc_valid_o  <= 1'b0;
      end
      else
      begin
         loop_mode_o   <= next_loop_sel;
         xcvr_loop_o   <= next_xcvr_loop;
         desc_status_o <= next_desc_status;
         desc_valid_o  <= next_desc_valid;
      end
   end

endmodule

// *** rfs_top_tb.sv ***
/*
 * rfs_top_tb: drives registers over APB and packets from the network.
 * Assumes rfs_top, rfs_net_model and rfs_sva are compiled first.
 */
`timescale 1ns/100ps
module rfs_top_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel, pen, pwr, pready, perr, er, st, en, col, car, xl, dv, c, cr;
   logic [11:0] pa;
   logic [31:0] pwd, prd, rd;
   logic [3:0] pst;
   logic [5:0] q, pk;
   logic [15:0] rc, rcv, ds;
   logic [1:0] lm;
   logic [16:0] lf = 17'h10340;
   int n_fail = 0;
   int tests_run = 0;
   int mode, eobt, fl, ex, lastd, i, k, ok;
   always #2.5 clk_i = ~clk_i;
   rfs_top i_rfs_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .pstrb_i(pst), .prdata_o(prd), .pready_o(pready), .pslverr_o(perr),
      .rx_start_i(st), .rx_end_i(en), .rx_accept_i(q[5]), .rx_group_i(q[4]),
      .rx_bcast_i(q[3]), .rx_fcs_bad_i(q[2]), .rx_misalign_i(q[1]),
      .rx_runt_i(q[0]), .rx_col_i(col), .carrier_activity_i(car),
      .remaining_word_count_i(rc), .loop_mode_o(lm), .xcvr_loop_o(xl),
      .desc_status_o(ds), .desc_valid_o(dv));
   rfs_net_model i_rfs_net_model (.clk_i(clk_i), .st_o(st), .en_o(en),
      .col_o(col), .car_o(car), .q_o(q), .rc_o(rc));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   function automatic logic [16:0] lfsr_step(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction
   // one idle edge first, so psel is never lowered and raised at once
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
      @(posedge clk_i);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      pst <= s;
      @(posedge clk_i);
      pen <= 1'b1;
      // only the watchdog ends a wait for the answer
      do
      begin
         @(posedge clk_i);
      end
      while (pready !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task give_verdict;
      $display("errors %0d checks %0d", n_fail, tests_run);
      if (n_fail == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      give_verdict;
   end
   initial
   begin
      {psel, pen, pwr, pa, pwd, pst} = '0;
      fl = 0;
      lastd = 0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (i = 0; i < 5; i++)
      begin
         apb(0, 12'(4 * i), 0, 4'hf);
         chk("reset", 0, rd);
         chk("slverr", i == 4, er);
      end
      for (i = 0; i < 8; i++)
      begin
         // transceiver loop also needs config-two bit 6
         apb(1, 12'h004, i[2] << 6, 4'h3);
         apb(1, 12'h000, {i[1:0], 9'h1ff}, 4'h3);
         // select shows one edge after the write, xcvr flag one later
         repeat (2) @(posedge clk_i);
         chk("loop", i[1:0], lm);
         chk("xcvr", i == 7, xl);
         apb(0, 12'h000, 0, 4'hf);
         chk("rcr", i[1:0] << 9, rd);
      end
      apb(1, 12'h000, 0, 4'h1);
      repeat (2) @(posedge clk_i);
      chk("lane", 3, lm);
      eobt = 32'h20;
      apb(1, 12'h008, eobt, 4'hf);
      apb(0, 12'h008, 0, 4'hf);
      chk("eobt", eobt, rd);
      for (k = 0; k < 24; k++)
      begin
         repeat (8) lf = lfsr_step(lf);
         mode = lf[1:0];
         apb(1, 12'h000, mode << 9, 4'hf);
         pk = {lf[2] | (mode != 0), lf[7:3]};
         c = lf[8];
         cr = lf[9];
         rcv = 16'h1e + lf[11:10];
         ex = mode << 9 | cr << 5 | (fl & 32'h10);
         fork
            i_rfs_net_model.send(pk, c, cr, rcv, 1 + lf[13:12]);
            begin
               apb(0, 12'h000, 0, 4'hf);
               chk("clear", ex, rd);
            end
         join
         ok = !pk[2] & !pk[0] & !c;
         fl = cr << 5 | c << 4 | (pk[2] & !pk[1]) << 3 | (pk[2] & pk[1]) << 2;
         fl = fl | ok | (ok & (mode != 0)) << 1;
         if (pk[5])
            fl = fl | pk[4] << 8 | pk[3] << 7 | (rcv <= eobt) << 6;
         ex = mode << 9 | fl;
         for (i = 0; i < 4 && dv !== 1'b1; i++)
            @(posedge clk_i);
         chk("dvalid", pk[5], dv === 1'b1);
         if (pk[5])
         begin
            chk("desc", ex, ds);
            lastd = ex;
         end
         apb(0, 12'h000, 0, 4'hf);
         chk("status", ex, rd);
         apb(0, 12'h00c, 0, 4'hf);
         chk("descreg", lastd, rd);
      end
      give_verdict;
   end
endmodule
bind rfs_top rfs_sva i_rfs_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .pready_o(pready_o), .rx_start_i(rx_start_i), .rx_end_i(rx_end_i),
   .rx_accept_i(rx_accept_i), .rx_group_i(rx_group_i),
   .rx_fcs_bad_i(rx_fcs_bad_i), .rx_misalign_i(rx_misalign_i),
   .rx_runt_i(rx_runt_i), .rx_col_i(rx_col_i), .loop_mode_o(loop_mode_o),
   .desc_status_o(desc_status_o), .desc_valid_o(desc_valid_o));
